// File: hw/adc_pkg.sv
package adc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int WORD_BITS = 16;
    localparam int LANES = 4;
    localparam int TMR_W = 21;
    localparam int LEAD_PERIODS = 2;
    localparam int SDR_PERIODS = LEAD_PERIODS + WORD_BITS;
    localparam int DDR_PERIODS = LEAD_PERIODS + WORD_BITS / 2 + 1;
    localparam int SDR_SCK_MHZ = 100;
    localparam int DDR_SCK_MHZ = 50;
    localparam int SDR_HALF_CYCLES = (CLK_MHZ + 2 * SDR_SCK_MHZ - 1) / (2 * SDR_SCK_MHZ);
    localparam int DDR_HALF_CYCLES = (CLK_MHZ + 2 * DDR_SCK_MHZ - 1) / (2 * DDR_SCK_MHZ);
    localparam int SETTLE_MS = 10;
    localparam int SETTLE_CYCLES = SETTLE_MS * CLK_MHZ * 1000;
    localparam int STROBE_HIGH_NS = 30;
    localparam int STROBE_HIGH_CYCLES = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_WAIT_CYCLES = 8;
    localparam int COPY_WAIT_CYCLES = 2;
    localparam logic [2:0] NAP_PULSES = 3'h2;
    localparam logic [2:0] SLEEP_PULSES = 3'h4;
    localparam logic [2:0] WAKE_PULSES = 3'h5;

    typedef logic [LANES-1:0][WORD_BITS-1:0] frame_t;

    typedef enum logic [2:0] {
        PWR_OPER = 3'h1,
        PWR_NAP = 3'h2,
        PWR_SLEEP = 3'h4
    } power_t;

    typedef enum logic [2:0] {
        CMD_CONVERT = 3'h1,
        CMD_PULSE = 3'h2,
        CMD_WAKE = 3'h4
    } cmd_t;

    typedef enum logic [7:0] {
        ST_POR = 8'h01,
        ST_IDLE = 8'h02,
        ST_HIGH = 8'h04,
        ST_CONV = 8'h08,
        ST_SHIFT = 8'h10,
        ST_COPY = 8'h20,
        ST_WAKE = 8'h40,
        ST_SETTLE = 8'h80
    } host_state_t;
endpackage : adc_pkg

// File: hw/adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
    logic shift_clk;
    logic conversion_strobe_n;
    logic [3:0] result_lane;
    logic [3:0] diff_result_lane_p;
    logic [3:0] diff_result_lane_n;
    logic echo_clock_out;
    logic echo_clock_out_n;

    modport device (
        input shift_clk,
        input conversion_strobe_n,
        output result_lane,
        output diff_result_lane_p,
        output diff_result_lane_n,
        output echo_clock_out,
        output echo_clock_out_n
    );

    modport host (
        output shift_clk,
        output conversion_strobe_n,
        input result_lane,
        input diff_result_lane_p,
        input diff_result_lane_n,
        input echo_clock_out,
        input echo_clock_out_n
    );
endinterface : adc_link_if
`default_nettype wire

// File: hw/adc_device.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Supply low holds core reset, reinit after
// - Controller waits 10 ms after power-on
// - Strobe rise samples, strobe fall converts
// - Shift clock edges time readout; clk times conversion
// - Strobe high about 30 ns, clean falling edge
// - Single rate: falling edge shifts MSB first
// - Double rate: both edges shift MSB first
// - Rate select low single, high double
// - Echo clock copies shift clock, lane aligned
// - Single rate lanes change falling, capture rising
// - Double rate receiver delays data, both edges
// - Echo disable input stops echo clock
// - Two strobe pulses, static clock, enter nap
// - Nap ends on shift rise or pulses
// - Two more pulses in nap enter sleep
// - CMOS: shift clock rise wakes from sleep
// - Controller waits 10 ms after sleep exit
// - Fifth pulse wakes; shift rise resets count except LVDS sleep
// - Bare pulses cycle power states forever
// - Signalling select picks CMOS or LVDS lanes
// - LVDS lane n carries channel n
// - One cycle latency, first result invalid
module adc_device (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supply_ok,
    input wire logic rate_select,
    input wire logic lvds_select,
    input wire logic echo_disable,
    input wire adc_pkg::frame_t sample_in,
    output var adc_pkg::power_t power_state,
    adc_link_if.device link
);
    import adc_pkg::*;

    function automatic logic [3:0] bit_index(
        input logic [4:0] cnt,
        input logic ddr,
        input logic rising
    );
        int idx;
        idx = (WORD_BITS - 1) - int'(cnt);
        if (ddr) begin
            idx = idx - int'(cnt) + (rising ? 1 : 0);
        end
        bit_index = 4'(idx);
    endfunction : bit_index

    // Core domain
    logic strb_s1_q, strb_s2_q, strb_s3_q;
    logic sup_s1_q, sup_s2_q;
    logic lvds_s1_q, lvds_s2_q;
    logic wake_s1_q, wake_s2_q, wake_s3_q;
    power_t state_q, state_d;
    logic [2:0] pulses_q, pulses_d;
    frame_t sample_q, sample_d;
    frame_t conv_q, conv_d;
    frame_t hold_q, hold_d;
    logic [1:0] fptr_q, fptr_d;
    logic wake_evt, strb_rise, strb_fall;

    // Link domain
    logic rise_tgl_q;
    logic [1:0] fptr_s1_q, fptr_s2_q, fptr_seen_q, fptr_seen_d;
    logic rate_s1_q, rate_s2_q;
    frame_t word_q, word_d;
    logic [4:0] cnt_q, cnt_d;
    logic act_q, act_d;
    logic [3:0] neg_q, neg_d;
    logic [3:0] pos_q, pos_d;
    logic [4:0] limit;
    logic [3:0] lane;

    assign wake_evt = wake_s2_q != wake_s3_q;
    assign strb_rise = strb_s2_q && !strb_s3_q;
    assign strb_fall = !strb_s2_q && strb_s3_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strb_s1_q <= 1'b0;
            strb_s2_q <= 1'b0;
            strb_s3_q <= 1'b0;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            lvds_s1_q <= 1'b0;
            lvds_s2_q <= 1'b0;
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end else begin
            strb_s1_q <= link.conversion_strobe_n;
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
            sup_s1_q <= supply_ok;
            sup_s2_q <= sup_s1_q;
            lvds_s1_q <= lvds_select;
            lvds_s2_q <= lvds_s1_q;
            wake_s1_q <= rise_tgl_q;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    always_comb begin
        state_d = state_q;
        pulses_d = pulses_q;
        sample_d = sample_q;
        conv_d = conv_q;
        hold_d = hold_q;
        fptr_d = fptr_q;
        if (!sup_s2_q) begin
            state_d = PWR_OPER;
            pulses_d = '0;
            sample_d = '0;
            conv_d = '0;
            hold_d = '0;
        end else begin
            if (wake_evt && !(state_q == PWR_SLEEP && lvds_s2_q)) begin
                pulses_d = '0;
                state_d = PWR_OPER;
            end
            if (strb_rise) begin
                if (state_q == PWR_OPER) begin
                    sample_d = sample_in;
                end
                pulses_d = pulses_d + 3'h1;
                if (pulses_d == NAP_PULSES) begin
                    state_d = PWR_NAP;
                end else if (pulses_d == SLEEP_PULSES) begin
                    state_d = PWR_SLEEP;
                end else if (pulses_d == WAKE_PULSES) begin
                    state_d = PWR_OPER;
                    pulses_d = '0;
                end
            end
            if (strb_fall && state_q == PWR_OPER) begin
                hold_d = conv_q;
                conv_d = sample_q;
                fptr_d = {fptr_q[0], !fptr_q[1]};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PWR_OPER;
            pulses_q <= '0;
            sample_q <= '0;
            conv_q <= '0;
            hold_q <= '0;
            fptr_q <= '0;
        end else begin
            state_q <= state_d;
            pulses_q <= pulses_d;
            sample_q <= sample_d;
            conv_q <= conv_d;
            hold_q <= hold_d;
            fptr_q <= fptr_d;
        end
    end

    assign power_state = state_q;

    // Falling shift edges: frame load and shifting
    assign limit = rate_s2_q ? 5'(WORD_BITS / 2) : 5'(WORD_BITS);

    always_comb begin
        fptr_seen_d = fptr_seen_q;
        word_d = word_q;
        cnt_d = cnt_q;
        act_d = act_q;
        neg_d = pos_q;
        if (fptr_s2_q != fptr_seen_q) begin
            fptr_seen_d = fptr_s2_q;
            word_d = hold_q;
            cnt_d = 5'h1;
            act_d = 1'b1;
            for (int i = 0; i < LANES; i++) begin
                neg_d[i] = hold_q[i][WORD_BITS-1] ^ pos_q[i];
            end
        end else if (act_q && cnt_q < limit) begin
            for (int i = 0; i < LANES; i++) begin
                neg_d[i] = word_q[i][bit_index(cnt_q, rate_s2_q, 1'b0)] ^ pos_q[i];
            end
            cnt_d = cnt_q + 5'h1;
        end else begin
            act_d = 1'b0;
        end
    end

    always_ff @(negedge link.shift_clk or negedge reset_n) begin
        if (!reset_n) begin
            fptr_s1_q <= '0;
            fptr_s2_q <= '0;
            fptr_seen_q <= '0;
            rate_s1_q <= 1'b0;
            rate_s2_q <= 1'b0;
            word_q <= '0;
            cnt_q <= '0;
            act_q <= 1'b0;
            neg_q <= '0;
        end else begin
            fptr_s1_q <= fptr_q;
            fptr_s2_q <= fptr_s1_q;
            fptr_seen_q <= fptr_seen_d;
            rate_s1_q <= rate_select;
            rate_s2_q <= rate_s1_q;
            word_q <= word_d;
            cnt_q <= cnt_d;
            act_q <= act_d;
            neg_q <= neg_d;
        end
    end

    // Rising shift edges: second half of double rate, wake events
    always_comb begin
        pos_d = pos_q;
        if (rate_s2_q && act_q && cnt_q != 5'h0 && cnt_q <= limit) begin
            for (int i = 0; i < LANES; i++) begin
                pos_d[i] = word_q[i][bit_index(cnt_q, 1'b1, 1'b1)] ^ neg_q[i];
            end
        end
    end

    always_ff @(posedge link.shift_clk or negedge reset_n) begin
        if (!reset_n) begin
            rise_tgl_q <= 1'b0;
            pos_q <= '0;
        end else begin
            rise_tgl_q <= !rise_tgl_q;
            pos_q <= pos_d;
        end
    end

    // Lanes change only on shift edges, never through a clock mux
    assign lane = neg_q ^ pos_q;
    assign link.result_lane = lvds_select ? 4'h0 : lane;
    assign link.diff_result_lane_p = lvds_select ? lane : 4'h0;
    assign link.diff_result_lane_n = lvds_select ? ~lane : 4'h0;
    assign link.echo_clock_out = !echo_disable && link.shift_clk;
    assign link.echo_clock_out_n = lvds_select && !echo_disable && !link.shift_clk;
endmodule : adc_device
`default_nettype wire

// File: hw/adc_host.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host #(
    parameter int SETTLE_WAIT = adc_pkg::SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rate_select,
    input wire logic lvds_select,
    input wire logic cmd_valid,
    input wire adc_pkg::cmd_t cmd,
    output logic cmd_ready,
    output var adc_pkg::frame_t result,
    output logic result_valid,
    output logic result_stale,
    adc_link_if.host link
);
    import adc_pkg::*;

    function automatic frame_t assemble(input frame_t p, input frame_t n, input logic ddr);
        frame_t w;
        w = p;
        if (ddr) begin
            for (int i = 0; i < LANES; i++) begin
                for (int k = 0; k < WORD_BITS / 2; k++) begin
                    w[i][2*k+1] = p[i][k+1];
                    w[i][2*k] = n[i][k];
                end
            end
        end
        assemble = w;
    endfunction : assemble

    host_state_t st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d, half;
    logic [4:0] per_q, per_d;
    logic sck_q, sck_d, strb_q, strb_d, conv_q, conv_d;
    logic [2:0] pulses_q, pulses_d;
    logic stale_q, stale_d, ready_q, ready_d;
    logic valid_q, valid_d, ostale_q, ostale_d;
    frame_t result_q, result_d, cap_p_q, cap_n_q;
    logic [3:0] lane_in;
    logic done;

    // Echo clock capture; double rate uses the opposite edge as data delay
    assign lane_in = lvds_select ? link.diff_result_lane_p : link.result_lane;

    always_ff @(posedge link.echo_clock_out or negedge reset_n) begin
        if (!reset_n) begin
            cap_p_q <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                cap_p_q[i] <= {cap_p_q[i][WORD_BITS-2:0], lane_in[i]};
            end
        end
    end

    always_ff @(negedge link.echo_clock_out or negedge reset_n) begin
        if (!reset_n) begin
            cap_n_q <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                cap_n_q[i] <= {cap_n_q[i][WORD_BITS-2:0], lane_in[i]};
            end
        end
    end

    assign half = rate_select ? TMR_W'(DDR_HALF_CYCLES - 1) : TMR_W'(SDR_HALF_CYCLES - 1);
    assign done = tmr_q == '0;

    always_comb begin
        st_d = st_q;
        tmr_d = done ? tmr_q : tmr_q - 1'b1;
        per_d = per_q;
        sck_d = sck_q;
        strb_d = strb_q;
        conv_d = conv_q;
        pulses_d = pulses_q;
        stale_d = stale_q;
        result_d = result_q;
        valid_d = 1'b0;
        ostale_d = ostale_q;
        unique case (st_q)
            ST_POR: if (done) st_d = ST_IDLE;
            ST_IDLE: if (cmd_valid) begin
                if (cmd == CMD_WAKE) begin
                    sck_d = 1'b0;
                    tmr_d = half;
                    st_d = ST_WAKE;
                end else begin
                    strb_d = 1'b1;
                    conv_d = cmd == CMD_CONVERT;
                    tmr_d = TMR_W'(STROBE_HIGH_CYCLES - 1);
                    st_d = ST_HIGH;
                end
            end
            ST_HIGH: if (done) begin
                strb_d = 1'b0;
                if (conv_q) begin
                    tmr_d = TMR_W'(CONV_WAIT_CYCLES - 1);
                    st_d = ST_CONV;
                end else begin
                    stale_d = 1'b1;
                    st_d = ST_IDLE;
                    pulses_d = pulses_q + 3'h1;
                    if (pulses_d == WAKE_PULSES) begin
                        pulses_d = '0;
                        tmr_d = TMR_W'(SETTLE_WAIT - 1);
                        st_d = ST_SETTLE;
                    end
                end
            end
            ST_CONV: if (done) begin
                pulses_d = '0;
                per_d = rate_select ? 5'(DDR_PERIODS - 1) : 5'(SDR_PERIODS - 1);
                sck_d = 1'b0;
                tmr_d = half;
                st_d = ST_SHIFT;
            end
            ST_SHIFT: if (done) begin
                sck_d = !sck_q;
                tmr_d = half;
                if (!sck_q) begin
                    per_d = per_q - 5'h1;
                    if (per_q == 5'h0) begin
                        tmr_d = TMR_W'(COPY_WAIT_CYCLES - 1);
                        st_d = ST_COPY;
                    end
                end
            end
            ST_COPY: if (done) begin
                result_d = assemble(cap_p_q, cap_n_q, rate_select);
                valid_d = 1'b1;
                ostale_d = stale_q;
                stale_d = 1'b0;
                st_d = ST_IDLE;
            end
            ST_WAKE: if (done) begin
                sck_d = 1'b1;
                st_d = ST_IDLE;
                if (pulses_q < SLEEP_PULSES || !lvds_select) begin
                    pulses_d = '0;
                    stale_d = 1'b1;
                end
                if (pulses_q >= SLEEP_PULSES && !lvds_select) begin
                    tmr_d = TMR_W'(SETTLE_WAIT - 1);
                    st_d = ST_SETTLE;
                end
            end
            ST_SETTLE: if (done) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
        ready_d = st_d == ST_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_POR;
            tmr_q <= TMR_W'(SETTLE_WAIT - 1);
            per_q <= '0;
            sck_q <= 1'b1;
            strb_q <= 1'b0;
            conv_q <= 1'b0;
            pulses_q <= '0;
            stale_q <= 1'b1;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            ostale_q <= 1'b0;
            result_q <= '0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            per_q <= per_d;
            sck_q <= sck_d;
            strb_q <= strb_d;
            conv_q <= conv_d;
            pulses_q <= pulses_d;
            stale_q <= stale_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            ostale_q <= ostale_d;
            result_q <= result_d;
        end
    end

    assign link.shift_clk = sck_q;
    assign link.conversion_strobe_n = strb_q;
    assign cmd_ready = ready_q;
    assign result = result_q;
    assign result_valid = valid_q;
    assign result_stale = ostale_q;
endmodule : adc_host
`default_nettype wire

// File: dv/adc_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module adc_link_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rate_select,
    input wire logic lvds_select,
    input wire logic echo_disable,
    input wire logic shift_clk,
    input wire logic conversion_strobe_n,
    input wire logic [3:0] result_lane,
    input wire logic [3:0] diff_result_lane_p,
    input wire logic [3:0] diff_result_lane_n,
    input wire logic echo_clock_out,
    input wire logic echo_clock_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ECHO_COPY: assert property (!echo_disable |-> echo_clock_out == shift_clk)
        else $error("echo clock differs from shift clock");
    AST_ECHO_OFF: assert property (echo_disable |-> !echo_clock_out && !echo_clock_out_n)
        else $error("echo clock active while disabled");
    AST_ECHO_DIFF: assert property (lvds_select && !echo_disable |-> echo_clock_out_n == !shift_clk)
        else $error("differential echo not inverse of shift clock");
    AST_LVDS_QUIET: assert property (lvds_select |-> result_lane == 4'h0)
        else $error("single ended lanes active in differential mode");
    AST_CMOS_QUIET: assert property (!lvds_select |-> diff_result_lane_p == 4'h0 && diff_result_lane_n == 4'h0)
        else $error("differential lanes active in single ended mode");
    AST_DIFF_PAIR: assert property (lvds_select |-> diff_result_lane_n == ~diff_result_lane_p)
        else $error("differential lane halves not complementary");
    AST_STROBE_WIDTH: assert property ($rose(conversion_strobe_n) |-> conversion_strobe_n [*4] ##1 !conversion_strobe_n)
        else $error("strobe pulse not four cycles wide");
    AST_STROBE_STATIC: assert property (conversion_strobe_n |-> shift_clk)
        else $error("shift clock moves during strobe pulse");
    AST_SDR_HOLD: assert property (!rate_select && shift_clk && $past(shift_clk) |-> $stable(result_lane))
        else $error("lanes change while shift clock high");

    cover property ($rose(conversion_strobe_n));
    cover property (lvds_select && diff_result_lane_p != 4'h0);
    cover property (echo_disable && !shift_clk);
endmodule : adc_link_assertions
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import adc_pkg::*;
    localparam int SETTLE = 50;
    logic clk = 1'b0;
    logic reset_n;
    logic supply_ok = 1'b1;
    logic rate_select = 1'b0;
    logic lvds_select = 1'b0;
    logic echo_disable = 1'b0;
    logic cmd_valid = 1'b0;
    cmd_t cmd = CMD_PULSE;
    frame_t sample_in = '0;
    power_t power_state;
    logic cmd_ready;
    frame_t result;
    logic result_valid;
    logic result_stale;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 32'h1b19_6d07;
    int cycles = 0;
    int falls = 0;
    int pc = 0;
    frame_t exp_q[$];
    cmd_t seq[11] = '{CMD_PULSE, CMD_PULSE, CMD_WAKE, CMD_PULSE, CMD_PULSE, CMD_PULSE, CMD_PULSE,
        CMD_WAKE, CMD_PULSE, CMD_PULSE, CMD_PULSE};

    adc_link_if link ();
    adc_device i_adc_device (.clk(clk), .reset_n(reset_n), .supply_ok(supply_ok), .rate_select(rate_select),
        .lvds_select(lvds_select), .echo_disable(echo_disable), .sample_in(sample_in),
        .power_state(power_state), .link(link));
    adc_host #(.SETTLE_WAIT(SETTLE)) i_adc_host (.clk(clk), .reset_n(reset_n), .rate_select(rate_select),
        .lvds_select(lvds_select), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .result(result),
        .result_valid(result_valid), .result_stale(result_stale), .link(link));
    adc_link_assertions i_adc_link_assertions (.clk(clk), .reset_n(reset_n), .rate_select(rate_select),
        .lvds_select(lvds_select), .echo_disable(echo_disable), .shift_clk(link.shift_clk),
        .conversion_strobe_n(link.conversion_strobe_n), .result_lane(link.result_lane),
        .diff_result_lane_p(link.diff_result_lane_p), .diff_result_lane_n(link.diff_result_lane_n),
        .echo_clock_out(link.echo_clock_out), .echo_clock_out_n(link.echo_clock_out_n));

    initial begin
        forever #4 clk = ~clk;
    end

    always @(negedge link.shift_clk) begin
        falls++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check("cmd_ready", 64'h1, {63'h0, cmd_ready});
    endtask : wait_ready

    task automatic send(input cmd_t c);
        wait_ready();
        cmd = c;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : send

    function automatic power_t model_state();
        case (pc)
            2, 3: return PWR_NAP;
            4: return PWR_SLEEP;
            default: return PWR_OPER;
        endcase
    endfunction : model_state

    // Pulses count up to five; a shift rise clears the count except in differential sleep
    task automatic power_cmd(input cmd_t c);
        send(c);
        if (c == CMD_PULSE) begin
            pc = (pc + 1) % 5;
        end else if (!lvds_select || pc != 4) begin
            pc = 0;
        end
        wait_ready();
        repeat (8) @(negedge clk);
        check("power_state", model_state(), power_state);
    endtask : power_cmd

    // Results lag one conversion; the first frame after reset carries zero
    task automatic convert(input logic stale_exp);
        int n;
        wait_ready();
        sample_in = {$random(seed), $random(seed)};
        exp_q.push_back(sample_in);
        falls = 0;
        send(CMD_CONVERT);
        n = 0;
        while (result_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check("result_valid", 64'h1, {63'h0, result_valid});
        check("result", exp_q.pop_front(), result);
        check("result_stale", stale_exp, result_stale);
        check("frame_falls", rate_select ? DDR_PERIODS : SDR_PERIODS, falls);
    endtask : convert

    task automatic do_reset(input int cfg);
        @(negedge clk);
        reset_n = 1'b0;
        rate_select = cfg[0];
        lvds_select = cfg[1];
        echo_disable = cfg[2];
        exp_q.delete();
        exp_q.push_back('0);
        pc = 0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
    endtask : do_reset

    initial begin
        // Non-blocking so every reset process sees the falling edge
        reset_n <= 1'b0;
        for (int cfg = 0; cfg < 5; cfg++) begin
            do_reset(cfg);
            if (cfg == 4) begin
                power_cmd(CMD_WAKE);
            end else begin
                for (int k = 0; k < 3; k++) begin
                    convert(k == 0);
                end
                foreach (seq[i]) begin
                    power_cmd(seq[i]);
                end
                supply_ok = 1'b0;
                repeat (10) @(negedge clk);
                supply_ok = 1'b1;
                repeat (10) @(negedge clk);
                pc = 0;
                check("power_after_supply", model_state(), power_state);
            end
            $display("config %0d done", cfg);
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
